// >>> shared/clock_output_control_defines.svh
// Purpose: Offsets, field positions, reset values and codes of the
//          clock output control registers.
// Assumes: Byte-wide registers behind the serial management port engine.
// Notes: Definitions only.
`ifndef CLOCK_OUTPUT_CONTROL_DEFINES_SVH
`define CLOCK_OUTPUT_CONTROL_DEFINES_SVH

// Register offsets.
`define FREEZE_SQUELCH_CONTROL_OFS 8'h03
`define CMOS_DRIVE_CONTROL_OFS 8'h05
`define OUTPUT_FORMAT_CONTROL_OFS 8'h06
`define OUTPUT_HOLD_CONTROL_OFS 8'h08

// Reset values.
`define FREEZE_SQUELCH_CONTROL_RST 8'h05
`define CMOS_DRIVE_CONTROL_RST 8'hed
`define OUTPUT_FORMAT_CONTROL_RST 8'h2d
`define OUTPUT_HOLD_CONTROL_RST 8'h00

// Writable bit masks; every other bit is reserved and read-only.
`define FREEZE_SQUELCH_CONTROL_WMASK 8'h30
`define CMOS_DRIVE_CONTROL_WMASK 8'hc0
`define OUTPUT_FORMAT_CONTROL_WMASK 8'h07
`define OUTPUT_HOLD_CONTROL_WMASK 8'h30

// Field positions.
`define OSCILLATOR_FREEZE_FORCE_BIT 5
`define SQUELCH_DURING_CALIBRATION_BIT 4
`define CMOS_DRIVE_STRENGTH_MSB 7
`define CMOS_DRIVE_STRENGTH_LSB 6
`define OUTPUT_SIGNAL_FORMAT_MSB 2
`define OUTPUT_SIGNAL_FORMAT_LSB 0
`define OUTPUT_STATIC_HOLD_MSB 5
`define OUTPUT_STATIC_HOLD_LSB 4

// Output signal format codes.
`define FORMAT_RESERVED_0 3'h0
`define FORMAT_DISABLE 3'h1
`define FORMAT_CMOS 3'h2
`define FORMAT_LVDS_LOW_SWING 3'h3
`define FORMAT_RESERVED_4 3'h4
`define FORMAT_LVPECL 3'h5
`define FORMAT_CML 3'h6
`define FORMAT_LVDS 3'h7

// Static hold codes.
`define HOLD_NORMAL 2'h0
`define HOLD_LOW 2'h1
`define HOLD_HIGH 2'h2

// CMOS drive step in milliamps per code step.
`define CMOS_DRIVE_STEP_MA 6'h08

`endif

// >>> shared/clock_output_control_pkg.sv
// Purpose: Types shared by the clock output control register bank.
// Assumes: Constants live in the defines header.
// Notes: States carry no explicit codes.
package clock_output_control_pkg;

  // States of the glitch-free hold stage.
  typedef enum logic [1:0] {
    follow,
    held_low,
    held_high
  } hold_state_e;

  // Register state of the control bank.
  typedef struct packed {
    logic [7:0] freeze_squelch_control_reg;
    logic [7:0] cmos_drive_control_reg;
    logic [7:0] output_format_control_reg;
    logic [7:0] output_hold_control_reg;
    logic [7:0] rdata_reg;
    logic freeze_reg;
    logic [1:0] drive_code_reg;
    logic [5:0] drive_ma_reg;
    logic [2:0] format_reg;
    logic enabled_reg;
    logic [1:0] hold_request_reg;
  } bank_state_s;

  // State of the hold stage.
  typedef struct packed {
    hold_state_e state_reg;
    logic raw_prev_reg;
    logic out_reg;
  } hold_stage_s;

endpackage : clock_output_control_pkg

// >>> shared/hold_if.sv
// Purpose: Carries the raw clock level, hold request and held clock.
// Assumes: All signals are in the system clock domain.
// Notes: One modport per side.
`timescale 1ns/1ns
`default_nettype none
interface hold_if;
  logic raw;
  logic [1:0] hold_code;
  logic out;

  modport ctrl (output raw, output hold_code, input out);
  modport stage (input raw, input hold_code, output out);
endinterface : hold_if
`default_nettype wire

// >>> core/output_hold_stage.sv
// Purpose: Glitch-free static hold of the clock output.
// Assumes: Raw clock level is synchronous to i_clk_sys.
// Notes: Hold is entered and left only on a matching raw edge.
`timescale 1ns/1ns
`default_nettype none
`include "clock_output_control_defines.svh"
module output_hold_stage
  import clock_output_control_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  hold_if.stage hold
);

  hold_stage_s s_reg;
  hold_stage_s s_next;
  logic fall;
  logic rise;

  // Edge detection on the raw clock level.
  assign fall = s_reg.raw_prev_reg & ~hold.raw;
  assign rise = ~s_reg.raw_prev_reg & hold.raw;

  // Next state: switching only at edges keeps every phase full length.
  always_comb begin
    s_next = s_reg;
    s_next.raw_prev_reg = hold.raw;
    case (s_reg.state_reg)
      follow: begin
        s_next.out_reg = hold.raw;
        if (hold.hold_code == `HOLD_LOW && fall) begin
          s_next.state_reg = held_low;
          s_next.out_reg = 1'b0;
        end else if (hold.hold_code == `HOLD_HIGH && rise) begin
          s_next.state_reg = held_high;
          s_next.out_reg = 1'b1;
        end
      end
      held_low: begin
        s_next.out_reg = 1'b0;
        if (hold.hold_code != `HOLD_LOW && fall) begin
          s_next.state_reg = follow;
        end
      end
      held_high: begin
        s_next.out_reg = 1'b1;
        if (hold.hold_code != `HOLD_HIGH && rise) begin
          s_next.state_reg = follow;
        end
      end
      default: begin
        s_next.state_reg = follow;
        s_next.out_reg = 1'b0;
      end
    endcase
  end

  // State register.
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      s_reg <= '{state_reg: follow, raw_prev_reg: 1'b0, out_reg: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign hold.out = s_reg.out_reg;

endmodule : output_hold_stage
`default_nettype wire

// >>> core/clock_output_control_regs.sv
// Purpose: Clock output control registers and the output gating they steer.
// Assumes: Register accesses come from the serial management port engine
//          as single-cycle byte strobes on i_clk_sys.
// Notes: Calibration state and the never-squelched control come from
//        neighbouring logic on the same clock.
//        Reserved format codes park the output low like the disable code.
`timescale 1ns/1ns
`default_nettype none
`include "clock_output_control_defines.svh"
// Notes on behaviour
// - Freeze bit forces oscillator freeze state.
// - Squelch bit disables outputs during calibration.
// - Drive field selects 8 to 32 mA.
// - Format field selects output buffer mode.
// - Hold field holds output low or high.
// - Hold entry and exit are glitch-free.
// - Never-squelched control overrides calibration squelch.
module clock_output_control_regs
  import clock_output_control_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_internal_calibration,
  input wire logic i_output_never_squelched,
  input wire logic i_raw_clock,
  output logic [7:0] o_reg_rdata,
  output logic o_oscillator_freeze_force,
  output logic [1:0] o_cmos_drive_strength,
  output logic [5:0] o_cmos_drive_ma,
  output logic [2:0] o_output_signal_format,
  output logic o_output_enabled,
  output logic o_clock_output
);

  bank_state_s s_reg;
  bank_state_s s_next;
  hold_if hold ();

  logic [1:0] drive_code;
  logic [2:0] format_code;
  logic [1:0] hold_code;
  logic squelch_cal;
  logic format_off;

  // Reset images of the stored registers, with their fields picked out so
  // that the registered outputs start consistent with the stored values.
  localparam logic [7:0] freeze_squelch_reset = `FREEZE_SQUELCH_CONTROL_RST;
  localparam logic [7:0] cmos_drive_reset = `CMOS_DRIVE_CONTROL_RST;
  localparam logic [7:0] output_format_reset = `OUTPUT_FORMAT_CONTROL_RST;
  localparam logic freeze_reset =
    freeze_squelch_reset[`OSCILLATOR_FREEZE_FORCE_BIT];
  localparam logic [1:0] drive_code_reset =
    cmos_drive_reset[`CMOS_DRIVE_STRENGTH_MSB:`CMOS_DRIVE_STRENGTH_LSB];
  localparam logic [2:0] format_reset =
    output_format_reset[`OUTPUT_SIGNAL_FORMAT_MSB:`OUTPUT_SIGNAL_FORMAT_LSB];
  // Calibration is taken as idle in reset, so only the format can disable.
  localparam logic enabled_reset = (format_reset != `FORMAT_DISABLE) &&
    (format_reset != `FORMAT_RESERVED_0) &&
    (format_reset != `FORMAT_RESERVED_4);
  localparam logic [5:0] drive_ma_reset = (format_reset == `FORMAT_CMOS) ?
    6'(({4'h0, drive_code_reset} + 6'h01) * `CMOS_DRIVE_STEP_MA) : 6'h00;

  // Field views of the stored registers.
  assign drive_code = s_reg.cmos_drive_control_reg[
    `CMOS_DRIVE_STRENGTH_MSB:`CMOS_DRIVE_STRENGTH_LSB];
  assign format_code = s_reg.output_format_control_reg[
    `OUTPUT_SIGNAL_FORMAT_MSB:`OUTPUT_SIGNAL_FORMAT_LSB];
  assign hold_code = s_reg.output_hold_control_reg[
    `OUTPUT_STATIC_HOLD_MSB:`OUTPUT_STATIC_HOLD_LSB];

  // Never-squelched wins.
  // Squelch acts through the hold stage, so it waits for a falling edge.
  assign squelch_cal =
    s_reg.freeze_squelch_control_reg[`SQUELCH_DURING_CALIBRATION_BIT] &
    i_internal_calibration & ~i_output_never_squelched;

  // Disable and reserved codes.
  // Reserved codes count as disabled so no undefined buffer mode runs.
  assign format_off = (format_code == `FORMAT_DISABLE) ||
                      (format_code == `FORMAT_RESERVED_0) ||
                      (format_code == `FORMAT_RESERVED_4);

  // Register writes, read answer and derived controls.
  always_comb begin
    s_next = s_reg;
    if (i_reg_wr) begin
      case (i_reg_addr)
        `FREEZE_SQUELCH_CONTROL_OFS: begin
          s_next.freeze_squelch_control_reg =
            (i_reg_wdata & `FREEZE_SQUELCH_CONTROL_WMASK) |
            (`FREEZE_SQUELCH_CONTROL_RST & ~`FREEZE_SQUELCH_CONTROL_WMASK);
        end
        `CMOS_DRIVE_CONTROL_OFS: begin
          s_next.cmos_drive_control_reg =
            (i_reg_wdata & `CMOS_DRIVE_CONTROL_WMASK) |
            (`CMOS_DRIVE_CONTROL_RST & ~`CMOS_DRIVE_CONTROL_WMASK);
        end
        `OUTPUT_FORMAT_CONTROL_OFS: begin
          s_next.output_format_control_reg =
            (i_reg_wdata & `OUTPUT_FORMAT_CONTROL_WMASK) |
            (`OUTPUT_FORMAT_CONTROL_RST & ~`OUTPUT_FORMAT_CONTROL_WMASK);
        end
        `OUTPUT_HOLD_CONTROL_OFS: begin
          s_next.output_hold_control_reg =
            (i_reg_wdata & `OUTPUT_HOLD_CONTROL_WMASK) |
            (`OUTPUT_HOLD_CONTROL_RST & ~`OUTPUT_HOLD_CONTROL_WMASK);
        end
        default: begin
          // Unmapped offsets ignore writes.
        end
      endcase
    end

    // Read data is registered; unmapped offsets answer zero.
    if (i_reg_rd) begin
      case (i_reg_addr)
        `FREEZE_SQUELCH_CONTROL_OFS: begin
          s_next.rdata_reg = s_reg.freeze_squelch_control_reg;
        end
        `CMOS_DRIVE_CONTROL_OFS: begin
          s_next.rdata_reg = s_reg.cmos_drive_control_reg;
        end
        `OUTPUT_FORMAT_CONTROL_OFS: begin
          s_next.rdata_reg = s_reg.output_format_control_reg;
        end
        `OUTPUT_HOLD_CONTROL_OFS: begin
          s_next.rdata_reg = s_reg.output_hold_control_reg;
        end
        default: begin
          s_next.rdata_reg = 8'h00;
        end
      endcase
    end

    s_next.freeze_reg =
      s_reg.freeze_squelch_control_reg[`OSCILLATOR_FREEZE_FORCE_BIT];

    // Drive current in CMOS only; the drive code follows its field in every format.
    // The current figure reads zero in other formats, where it means nothing.
    s_next.drive_code_reg = drive_code;
    if (format_code == `FORMAT_CMOS) begin
      s_next.drive_ma_reg = 6'(({4'h0, drive_code} + 6'h01) *
                               `CMOS_DRIVE_STEP_MA);
    end else begin
      s_next.drive_ma_reg = 6'h00;
    end

    // Format and enable follow the stored fields one cycle later.
    s_next.format_reg = format_code;
    s_next.enabled_reg = ~format_off & ~squelch_cal;

    // Hold request mapping.
    // A disabled or squelched output parks low through the same glitch-free
    // path; the reserved code 11 lets the clock run.
    if (format_off || squelch_cal) begin
      s_next.hold_request_reg = `HOLD_LOW;
    end else begin
      case (hold_code)
        `HOLD_LOW: begin
          s_next.hold_request_reg = `HOLD_LOW;
        end
        `HOLD_HIGH: begin
          s_next.hold_request_reg = `HOLD_HIGH;
        end
        default: begin
          s_next.hold_request_reg = `HOLD_NORMAL;
        end
      endcase
    end
  end

  // State register with printed reset values.
  // Derived outputs reset to what their fields would give after one cycle.
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      s_reg <= '{
        freeze_squelch_control_reg: `FREEZE_SQUELCH_CONTROL_RST,
        cmos_drive_control_reg: `CMOS_DRIVE_CONTROL_RST,
        output_format_control_reg: `OUTPUT_FORMAT_CONTROL_RST,
        output_hold_control_reg: `OUTPUT_HOLD_CONTROL_RST,
        rdata_reg: 8'h00,
        freeze_reg: freeze_reset,
        drive_code_reg: drive_code_reset,
        drive_ma_reg: drive_ma_reset,
        format_reg: format_reset,
        enabled_reg: enabled_reset,
        hold_request_reg: enabled_reset ? `HOLD_NORMAL : `HOLD_LOW
      };
    end else begin
      s_reg <= s_next;
    end
  end

  // Glitch-free output stage fed by the registered hold request.
  // The stage only switches at raw edges, so no runt pulse reaches the pin.
  assign hold.raw = i_raw_clock;
  assign hold.hold_code = s_reg.hold_request_reg;

  output_hold_stage u_hold (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .hold(hold.stage)
  );

  // Outputs straight from flip-flops.
  assign o_reg_rdata = s_reg.rdata_reg;
  assign o_oscillator_freeze_force = s_reg.freeze_reg;
  assign o_cmos_drive_strength = s_reg.drive_code_reg;
  assign o_cmos_drive_ma = s_reg.drive_ma_reg;
  assign o_output_signal_format = s_reg.format_reg;
  assign o_output_enabled = s_reg.enabled_reg;
  assign o_clock_output = hold.out;

endmodule : clock_output_control_regs
`default_nettype wire

// >>> test/clock_output_control_regs_props.sv
// Purpose: Port assertions for the clock output control bank.
// Assumes: Raw clock holds each level for at least two cycles.
// Notes: Bound to every instance of the bank.
`timescale 1ns/1ns
`default_nettype none
module clock_output_control_regs_props (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_internal_calibration,
  input wire logic i_output_never_squelched,
  input wire logic i_raw_clock,
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_oscillator_freeze_force,
  input wire logic [1:0] o_cmos_drive_strength,
  input wire logic [5:0] o_cmos_drive_ma,
  input wire logic [2:0] o_output_signal_format,
  input wire logic o_output_enabled,
  input wire logic o_clock_output
);
  logic [1:0] hold_sh;
  logic sq_sh;
  logic [3:0] low_cnt;
  logic [3:0] fol_cnt;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  // Shadows of written fields and settle counters.
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      hold_sh <= 2'h0;
      sq_sh <= 1'b0;
      low_cnt <= 4'h0;
      fol_cnt <= 4'h0;
    end else begin
      if (i_reg_wr && i_reg_addr == 8'h08) begin
        hold_sh <= i_reg_wdata[5:4];
      end
      if (i_reg_wr && i_reg_addr == 8'h03) begin
        sq_sh <= i_reg_wdata[4];
      end
      low_cnt <= (hold_sh != 2'h1) ? 4'h0 :
        low_cnt + {3'h0, low_cnt != 4'hf};
      fol_cnt <= (hold_sh[0] != hold_sh[1] || !o_output_enabled) ? 4'h0 :
        fol_cnt + {3'h0, fol_cnt != 4'hf};
    end
  end
  // Reserved mask in the upper byte, read value in the lower.
  function automatic logic [15:0] rsv(input logic [7:0] a);
    case (a)
      8'h03: rsv = 16'hcf05;
      8'h05: rsv = 16'h3f2d;
      8'h06: rsv = 16'hf828;
      8'h08: rsv = 16'hcf00;
      default: rsv = 16'hff00;
    endcase
  endfunction : rsv
  // Write strobe to one offset.
  sequence s_wr(logic [7:0] a);
    i_reg_wr && i_reg_addr == a;
  endsequence
  property p_frz;
    logic d;
    (s_wr(8'h03), d = i_reg_wdata[5]) |-> ##2 o_oscillator_freeze_force == d;
  endproperty
  property p_drv;
    logic [1:0] d;
    (s_wr(8'h05), d = i_reg_wdata[7:6]) |-> ##2 o_cmos_drive_strength == d;
  endproperty
  property p_ma;
    o_cmos_drive_ma == ((o_output_signal_format == 3'h2) ?
      {1'b0, o_cmos_drive_strength, 3'h0} + 6'h08 : 6'h00);
  endproperty
  property p_off;
    o_output_signal_format inside {3'h0, 3'h1, 3'h4} |-> !o_output_enabled;
  endproperty
  property p_sq;
    (sq_sh && i_internal_calibration && !i_output_never_squelched) [*3]
      |-> !o_output_enabled;
  endproperty
  property p_on;
    (i_output_never_squelched &&
      !(o_output_signal_format inside {3'h0, 3'h1, 3'h4})) [*3]
      |-> o_output_enabled;
  endproperty
  property p_rsv;
    logic [15:0] r;
    (i_reg_rd, r = rsv(i_reg_addr)) |=> (o_reg_rdata & r[15:8]) == r[7:0];
  endproperty
  property p_glitch;
    $changed(o_clock_output) |=> $stable(o_clock_output);
  endproperty
  property p_low;
    low_cnt >= 4'ha |-> !o_clock_output;
  endproperty
  property p_fol;
    fol_cnt >= 4'ha |-> o_clock_output == $past(i_raw_clock);
  endproperty
  a_frz: assert property (p_frz) else $error("freeze output wrong");
  a_drv: assert property (p_drv) else $error("drive code wrong");
  a_ma: assert property (p_ma) else $error("drive current wrong");
  a_off: assert property (p_off) else $error("disabled format on");
  a_sq: assert property (p_sq) else $error("not squelched");
  a_on: assert property (p_on) else $error("squelch not bypassed");
  a_rsv: assert property (p_rsv) else $error("reserved bits wrong");
  a_glitch: assert property (p_glitch) else $error("short pulse");
  a_low: assert property (p_low) else $error("hold low lost");
  a_fol: assert property (p_fol) else $error("output not following");
endmodule : clock_output_control_regs_props
bind clock_output_control_regs clock_output_control_regs_props u_props (
  .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_reg_wr(i_reg_wr),
  .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
  .i_internal_calibration(i_internal_calibration),
  .i_output_never_squelched(i_output_never_squelched),
  .i_raw_clock(i_raw_clock), .o_reg_rdata(o_reg_rdata),
  .o_oscillator_freeze_force(o_oscillator_freeze_force),
  .o_cmos_drive_strength(o_cmos_drive_strength),
  .o_cmos_drive_ma(o_cmos_drive_ma),
  .o_output_signal_format(o_output_signal_format),
  .o_output_enabled(o_output_enabled), .o_clock_output(o_clock_output));
`default_nettype wire

// >>> test/clock_output_control_regs_tb.sv
// Purpose: Self-checking bench for the clock output control bank.
// Assumes: Inputs change on the falling clock edge.
// Notes: Read data is matched against a queue of expected bytes.
`timescale 1ns/1ns
`default_nettype none
`include "clock_output_control_defines.svh"
module clock_output_control_regs_tb;
  logic i_clk_sys = 1'b0;
  logic i_resetn = 1'b0;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic [7:0] i_reg_addr = 8'h00;
  logic [7:0] i_reg_wdata = 8'h00;
  logic cal = 1'b0;
  logic nsq = 1'b0;
  logic raw = 1'b0;
  logic raw_d = 1'b0;
  logic rd_d = 1'b0;
  logic [7:0] rdata;
  logic frz;
  logic [1:0] drv;
  logic [5:0] ma;
  logic [2:0] fmt;
  logic en;
  logic cko;
  logic [7:0] m [0:15];
  logic [7:0] exp_q [$];
  logic [7:0] adr [5] = '{8'h03, 8'h05, 8'h06, 8'h08, 8'h13};
  logic [1:0] hv [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
  logic [7:0] a;
  int error_cnt = 0;
  int n_compared = 0;
  clock_output_control_regs uut (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_internal_calibration(cal),
    .i_output_never_squelched(nsq), .i_raw_clock(raw), .o_reg_rdata(rdata),
    .o_oscillator_freeze_force(frz), .o_cmos_drive_strength(drv),
    .o_cmos_drive_ma(ma), .o_output_signal_format(fmt),
    .o_output_enabled(en), .o_clock_output(cko));
  // Free-running system clock.
  always #4 i_clk_sys = ~i_clk_sys;
  // Raw clock holds each level for two cycles.
  always begin
    repeat (2) @(negedge i_clk_sys);
    raw = ~raw;
  end
  // Counts a comparison and reports a mismatch.
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_compared++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  // Delayed copies of the read strobe and raw level.
  always @(posedge i_clk_sys) begin
    rd_d <= i_reg_rd;
    raw_d <= raw;
  end
  // Read data appears one cycle after the strobe.
  always @(negedge i_clk_sys) begin
    if (rd_d) begin
      chk(rdata, exp_q.pop_front());
    end
  end
  // Writable bits per offset; zero means unmapped.
  function automatic logic [7:0] wm(input logic [7:0] x);
    case (x)
      `FREEZE_SQUELCH_CONTROL_OFS: wm = `FREEZE_SQUELCH_CONTROL_WMASK;
      `CMOS_DRIVE_CONTROL_OFS: wm = `CMOS_DRIVE_CONTROL_WMASK;
      `OUTPUT_FORMAT_CONTROL_OFS: wm = `OUTPUT_FORMAT_CONTROL_WMASK;
      `OUTPUT_HOLD_CONTROL_OFS: wm = `OUTPUT_HOLD_CONTROL_WMASK;
      default: wm = 8'h00;
    endcase
  endfunction : wm
  // One write strobe; the mirror keeps only writable bits.
  task automatic wr(input logic [7:0] x, input logic [7:0] d);
    @(negedge i_clk_sys);
    i_reg_wr = 1'b1;
    i_reg_addr = x;
    i_reg_wdata = d;
    m[x[3:0]] = (m[x[3:0]] & ~wm(x)) | (d & wm(x));
    @(negedge i_clk_sys);
    i_reg_wr = 1'b0;
  endtask : wr
  // One read strobe; the expected byte goes on the queue.
  task automatic rd(input logic [7:0] x);
    @(negedge i_clk_sys);
    i_reg_rd = 1'b1;
    i_reg_addr = x;
    exp_q.push_back((wm(x) == 8'h00) ? 8'h00 : m[x[3:0]]);
    @(negedge i_clk_sys);
    i_reg_rd = 1'b0;
  endtask : rd
  // Prints the counts and the verdict, then stops.
  task automatic wrap_up;
    $display("compared %0d mismatched %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up
  // Cuts a hang short.
  initial begin
    repeat (5000) @(posedge i_clk_sys);
    error_cnt++;
    wrap_up();
  end
  // Main sequence of tests.
  initial begin
    m = '{default: 8'h00};
    m[3] = `FREEZE_SQUELCH_CONTROL_RST;
    m[5] = `CMOS_DRIVE_CONTROL_RST;
    m[6] = `OUTPUT_FORMAT_CONTROL_RST;
    m[8] = `OUTPUT_HOLD_CONTROL_RST;
    void'($urandom(32'h4959));
    repeat (20) @(negedge i_clk_sys);
    i_resetn = 1'b1;
    chk(frz, 8'h00);
    chk(fmt, 8'h05);
    for (int i = 0; i < 5; i++) begin
      rd(adr[i]);
    end
    $display("test reset values done");
    for (int i = 0; i < 40; i++) begin
      a = adr[$urandom_range(4)];
      wr(a, 8'($urandom));
      rd(a);
    end
    $display("test random access done");
    for (int b = 1; b >= 0; b--) begin
      wr(8'h03, 8'(b << 5));
      repeat (2) @(negedge i_clk_sys);
      chk(frz, 8'(b));
    end
    $display("test freeze done");
    wr(8'h08, 8'h00);
    // The bench stands for a 2.5 V part, so LVPECL may be set.
    cal = 1'b1;
    for (int f = 0; f < 8; f++) begin
      for (int c = 0; c < 4; c++) begin
        wr(8'h06, 8'(f));
        wr(8'h05, 8'(c << 6));
        repeat (2) @(negedge i_clk_sys);
        chk(fmt, 8'(f));
        chk(en, 8'(!(f == 0 || f == 1 || f == 4)));
        chk(drv, 8'(c));
        chk(ma, (f == 2) ? 8'(8 * (c + 1)) : 8'h00);
      end
    end
    $display("test format and drive done");
    wr(8'h03, 8'h10);
    repeat (2) @(negedge i_clk_sys);
    chk(en, 8'h00);
    nsq = 1'b1;
    repeat (3) @(negedge i_clk_sys);
    chk(en, 8'h01);
    nsq = 1'b0;
    cal = 1'b0;
    repeat (3) @(negedge i_clk_sys);
    chk(en, 8'h01);
    $display("test squelch done");
    for (int i = 0; i < 4; i++) begin
      wr(8'h08, {2'h0, hv[i], 4'h0});
      repeat (12) @(negedge i_clk_sys);
      repeat (8) begin
        @(negedge i_clk_sys);
        chk(cko, (hv[i] == 2'h1) ? 8'h00 :
          (hv[i] == 2'h2) ? 8'h01 : {7'h00, raw_d});
      end
    end
    $display("test static hold done");
    wrap_up();
  end
endmodule : clock_output_control_regs_tb
`default_nettype wire
